//--- pkg/serial_audio_pkg.sv
// serial_audio_pkg: register map, field layout, reset values and timing of the serial audio block
package serial_audio_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] CSR_OFS  = 4'h0;
    localparam logic [3:0] FIFO_OFS = 4'h4;
    localparam logic [3:0] MODE_OFS = 4'h8;

    // ------------------------------------------------------------------
    // main control / status fields
    // ------------------------------------------------------------------
    localparam int EN_BIT      = 0;
    localparam int RX_RUN_BIT  = 1;
    localparam int TX_RUN_BIT  = 2;
    localparam int TX_CLR_BIT  = 3;
    localparam int RX_CLR_BIT  = 4;
    localparam int TX_THR_LSB  = 5;
    localparam int TX_THR_MSB  = 6;
    localparam int TXW_BIT     = 17;
    localparam int TXD_BIT     = 19;
    localparam int RXD_BIT     = 20;
    localparam int TXE_BIT     = 21;

    // ------------------------------------------------------------------
    // operating mode fields
    // ------------------------------------------------------------------
    localparam int DIR_BIT     = 23;
    localparam int TX_PACK_BIT = 24;
    localparam int RX_PACK_BIT = 25;
    localparam int DEN_EN_BIT  = 26;
    localparam int DEN_SEL_BIT = 27;
    localparam int BIT_CLOCK_DISABLE_BIT = 28;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [6:0]  CSR_CTRL_RST = 7'h00;
    localparam logic [5:0]  MODE_RST     = 6'h00;
    localparam logic [31:0] FIFO_RST     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // timing and framing
    // ------------------------------------------------------------------
    localparam int REF_PERIOD_NS  = 20;
    localparam int BCLK_PERIOD_NS = 160;
    localparam int BCLK_HALF_CYC  = (BCLK_PERIOD_NS / (2 * REF_PERIOD_NS) < 1) ? 1 :
                                    BCLK_PERIOD_NS / (2 * REF_PERIOD_NS);
    localparam int CLR_BCLKS      = 2;
    localparam int CH_BITS        = 32;
    localparam int PACK_BITS      = 16;
    localparam int DEC_LO         = 16;
    localparam int DEC_HI         = 32;

    typedef enum logic [1:0] {
        THR_EMPTY       = 2'b00,
        THR_QUARTER     = 2'b01,
        THR_3QUARTER    = 2'b10,
        THR_ALMOST_FULL = 2'b11
    } tx_thr_t;

endpackage

//--- core/serial_audio_core.sv
// serial_audio_core: two-channel serial audio interface with wishbone registers and fifos
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
// Function
// - transmit-needs-writing flag follows two-bit threshold: empty, quarter, three quarters, full-but-one.
// - writing one to receive clear empties receive fifo two bit clocks later; reads zero.
// - writing one to transmit clear empties transmit fifo two bit clocks later; reads zero.
// - clearing transmit run stops transmission at frame end; fifo writes still accepted.
// - setting transmit run starts at next frame; first fifo word fills first channel.
// - frame counter starts whenever transmit run or receive run is set.
// - clearing receive run halts reception at frame end; fifo stays readable.
// - setting receive run starts at next frame; first channel is first word pushed.
// - enable zero disables the interface and holds its logic idle.
// - enable and run bits accept writes while the interface is running.
// - data port writes push transmit fifo; reads pop receive fifo.
// - clock disable stops the driven bit clock cleanly, parked low; an input bit clock is ignored.
// - decimation select picks filter factor sixteen or thirty-two.
// - density input enable routes data pin through decimation filter; needs receive run.
// - receive packing merges both channels in one word, first channel low, truncated.
// - transmit packing splits a word into two halves, low half first channel.
// - bit clock direction zero drives bit clock out, one takes it in.
// - needs-writing flag reads one while fill level is below the threshold, or at it for empty and full-but-one.
module serial_audio_core
    import serial_audio_pkg::*;
#(
    parameter int DEPTH      = 64,
    parameter int FRAME_BITS = 64,
    parameter int HALF_CYC   = BCLK_HALF_CYC
) (
    // system
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // wishbone slave
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    input  wire logic [3:0]  adr,
    input  wire logic [3:0]  sel,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata,
    output logic             ack,
    // serial link
    input  wire logic        bclk_pin,
    output logic             bclk_drive,
    output logic             bclk_drive_en,
    output logic             fs_drive,
    output logic             fs_drive_en,
    input  wire logic        data_in,
    output logic             data_out,
    output logic             data_out_en
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = AW + 1;
    localparam int FW = $clog2(FRAME_BITS);
    localparam int DW = $clog2(HALF_CYC + 1);

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || FRAME_BITS < 2 * CH_BITS || HALF_CYC < 1) begin : g_chk
        $error("serial_audio_core: unsupported parameter values");
    end

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic thr_hit(input logic [LW-1:0] lvl, input logic [1:0] s);
        case (s)
            THR_EMPTY:    return lvl == '0;
            THR_QUARTER:  return lvl < LW'(DEPTH / 4);
            THR_3QUARTER: return lvl < LW'((3 * DEPTH) / 4);
            default:      return lvl < LW'(DEPTH);
        endcase
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic             ctrl_en_q, rx_run_q, tx_run_q;
    logic [1:0]       tx_thr_q;
    logic             bit_clock_disable_q, dec_sel_q, den_en_q, rx_pack_q, tx_pack_q, dir_q;
    logic             req, wr, rd, tx_need;
    logic [31:0]      csr_val, mode_val, csr_new, mode_new;
    logic [1:0]       clr_req, f_push, f_pop, f_clr;
    logic [31:0]      f_wdata [2];
    logic [31:0]      f_head [2];
    logic [LW-1:0]    f_lvl [2];
    logic [1:0]       sync1_q, sync2_q;
    logic             bclk_s3_q, bclk_q;
    logic [DW-1:0]    div_q;
    logic             tick, bit_rise, bit_fall, din;
    logic             frame_on_q, tx_act_q, rx_act_q, fs_q;
    logic [FW-1:0]    cnt_q;
    logic             want, boundary, slot_load, tx_go, tx_pop;
    logic [31:0]      tx_sh_q, rx_sh_q, rx_word, rx_data;
    logic [15:0]      tx_hold_q, rx_lo_q;
    logic             rx_push, rx_last, den_push;
    logic [5:0]       den_acc_q;
    logic [4:0]       den_cnt_q;

    // ------------------------------------------------------------------
    // wishbone slave: one wait state, ack for one cycle
    // ------------------------------------------------------------------
    assign req = cyc && stb && !ack;
    assign wr  = req && we;
    assign rd  = req && !we;

    always_comb begin
        csr_val = '0;
        csr_val[EN_BIT] = ctrl_en_q;
        csr_val[RX_RUN_BIT] = rx_run_q;
        csr_val[TX_RUN_BIT] = tx_run_q;
        csr_val[TX_THR_MSB:TX_THR_LSB] = tx_thr_q;
        csr_val[TXW_BIT] = tx_need;
        csr_val[TXD_BIT] = f_lvl[0] != LW'(DEPTH);
        csr_val[RXD_BIT] = f_lvl[1] != '0;
        csr_val[TXE_BIT] = f_lvl[0] == '0;
        mode_val = '0;
        mode_val[BIT_CLOCK_DISABLE_BIT:DIR_BIT] = {bit_clock_disable_q, dec_sel_q, den_en_q, rx_pack_q, tx_pack_q, dir_q};
    end

    assign csr_new  = merge(csr_val, wdata, sel);
    assign mode_new = merge(mode_val, wdata, sel);
    assign tx_need  = thr_hit(f_lvl[0], tx_thr_q);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ack   <= 1'b0;
            rdata <= FIFO_RST;
        end else begin
            ack <= req;
            if (rd) begin
                case (adr)
                    CSR_OFS:  rdata <= csr_val;
                    FIFO_OFS: rdata <= (f_lvl[1] != '0) ? f_head[1] : FIFO_RST;
                    MODE_OFS: rdata <= mode_val;
                    default:  rdata <= '0;
                endcase
            end else if (wr) begin
                rdata <= '0;
            end
        end
    end

    // control bits stay writable at any time; software keeps the rest steady
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            {tx_thr_q, tx_run_q, rx_run_q, ctrl_en_q} <= {CSR_CTRL_RST[6:5], CSR_CTRL_RST[2:0]};
        end else if (wr && adr == CSR_OFS) begin
            ctrl_en_q <= csr_new[EN_BIT];
            rx_run_q  <= csr_new[RX_RUN_BIT];
            tx_run_q  <= csr_new[TX_RUN_BIT];
            tx_thr_q  <= csr_new[TX_THR_MSB:TX_THR_LSB];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            {bit_clock_disable_q, dec_sel_q, den_en_q, rx_pack_q, tx_pack_q, dir_q} <= MODE_RST;
        end else if (wr && adr == MODE_OFS) begin
            {bit_clock_disable_q, dec_sel_q, den_en_q, rx_pack_q, tx_pack_q, dir_q} <= mode_new[BIT_CLOCK_DISABLE_BIT:DIR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // fifo clear requests, completed on the second bit clock rise
    // ------------------------------------------------------------------
    assign clr_req[0] = wr && adr == CSR_OFS && sel[0] && wdata[TX_CLR_BIT];
    assign clr_req[1] = wr && adr == CSR_OFS && sel[0] && wdata[RX_CLR_BIT];

    for (genvar i = 0; i < 2; i++) begin : g_clr
        logic       pend_q;
        logic [1:0] seen_q;
        // limitation: with the bit clock stopped the clear waits until it runs again
        assign f_clr[i] = pend_q && bit_rise && seen_q == 2'(CLR_BCLKS - 1);
        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                pend_q <= 1'b0;
                seen_q <= 2'h0;
            end else if (clr_req[i]) begin
                pend_q <= 1'b1;
                seen_q <= 2'h0;
            end else if (f_clr[i]) begin
                pend_q <= 1'b0;
            end else if (pend_q && bit_rise) begin
                seen_q <= seen_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // fifos: index 0 transmit, index 1 receive
    // ------------------------------------------------------------------
    assign f_push[0]  = wr && adr == FIFO_OFS;
    assign f_wdata[0] = wdata;
    assign f_pop[0]   = tx_pop;
    assign f_push[1]  = rx_push;
    assign f_wdata[1] = rx_data;
    assign f_pop[1]   = rd && adr == FIFO_OFS;

    for (genvar i = 0; i < 2; i++) begin : g_fifo
        logic [31:0]   mem [DEPTH];
        logic [AW-1:0] wp_q, rp_q;
        logic [LW-1:0] lvl_q;
        logic          do_push, do_pop;
        // pushes beyond full are dropped, pops of an empty fifo do nothing
        assign do_push   = f_push[i] && lvl_q != LW'(DEPTH);
        assign do_pop    = f_pop[i] && lvl_q != '0;
        assign f_head[i] = mem[rp_q];
        assign f_lvl[i]  = lvl_q;
        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                wp_q  <= '0;
                rp_q  <= '0;
                lvl_q <= '0;
            end else if (f_clr[i]) begin
                wp_q  <= '0;
                rp_q  <= '0;
                lvl_q <= '0;
            end else begin
                if (do_push) begin
                    wp_q <= wp_q + AW'(1);
                end
                if (do_pop) begin
                    rp_q <= rp_q + AW'(1);
                end
                lvl_q <= lvl_q + LW'(do_push) - LW'(do_pop);
            end
        end
        always_ff @(posedge ref_clk) begin
            if (do_push) begin
                mem[wp_q] <= f_wdata[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers and bit clock
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_q   <= 2'h0;
            sync2_q   <= 2'h0;
            bclk_s3_q <= 1'b0;
        end else begin
            sync1_q   <= {data_in, bclk_pin};
            sync2_q   <= sync1_q;
            bclk_s3_q <= sync2_q[0];
        end
    end
    assign din = sync2_q[1];

    // master clock parks low: on clock disable a high phase completes before stopping; enable zero or direction one drops it at once
    assign tick = div_q == DW'(HALF_CYC - 1);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_q  <= '0;
            bclk_q <= 1'b0;
        end else if (!ctrl_en_q || dir_q) begin
            div_q  <= '0;
            bclk_q <= 1'b0;
        end else if (tick) begin
            div_q <= '0;
            if (bclk_q || !bit_clock_disable_q) begin
                bclk_q <= ~bclk_q;
            end
        end else begin
            div_q <= div_q + DW'(1);
        end
    end

    assign bit_rise = ctrl_en_q && !bit_clock_disable_q &&
                      (dir_q ? (sync2_q[0] && !bclk_s3_q) : (tick && !bclk_q));
    assign bit_fall = ctrl_en_q && (dir_q ? (!bit_clock_disable_q && !sync2_q[0] && bclk_s3_q) : (tick && bclk_q));
    assign bclk_drive    = bclk_q;
    assign bclk_drive_en = !dir_q;

    // ------------------------------------------------------------------
    // frame counter; run bits are taken only at frame boundaries
    // ------------------------------------------------------------------
    assign want      = rx_run_q || tx_run_q;
    assign boundary  = !frame_on_q || cnt_q == FW'(FRAME_BITS - 1);
    assign slot_load = bit_rise && (boundary ? want : cnt_q == FW'(CH_BITS - 1));
    assign tx_go     = boundary ? tx_run_q : tx_act_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            frame_on_q <= 1'b0;
            cnt_q      <= '0;
            tx_act_q   <= 1'b0;
            rx_act_q   <= 1'b0;
            fs_q       <= 1'b0;
        end else if (!ctrl_en_q) begin
            frame_on_q <= 1'b0;
            cnt_q      <= '0;
            tx_act_q   <= 1'b0;
            rx_act_q   <= 1'b0;
            fs_q       <= 1'b0;
        end else if (bit_rise) begin
            fs_q <= boundary && want;
            if (boundary) begin
                frame_on_q <= want;
                cnt_q      <= '0;
                tx_act_q   <= tx_run_q;
                rx_act_q   <= rx_run_q;
            end else begin
                cnt_q <= cnt_q + FW'(1);
            end
        end
    end
    assign fs_drive    = fs_q;
    assign fs_drive_en = 1'b1;

    // ------------------------------------------------------------------
    // transmit shifter, msb first; underflow sends zeros except in a packed second channel, which sends the held half
    // ------------------------------------------------------------------
    assign tx_pop = slot_load && tx_go && (!tx_pack_q || boundary) && f_lvl[0] != '0;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_sh_q   <= '0;
            tx_hold_q <= '0;
        end else if (slot_load) begin
            if (!tx_go || (f_lvl[0] == '0 && (!tx_pack_q || boundary))) begin
                tx_sh_q <= '0;
            end else if (!tx_pack_q) begin
                tx_sh_q <= f_head[0];
            end else if (boundary) begin
                tx_sh_q   <= {f_head[0][PACK_BITS-1:0], 16'h0000};
                tx_hold_q <= f_head[0][31:PACK_BITS];
            end else begin
                tx_sh_q <= {tx_hold_q, 16'h0000};
            end
        end else if (bit_rise) begin
            tx_sh_q <= {tx_sh_q[30:0], 1'b0};
        end
    end
    assign data_out    = tx_sh_q[31];
    assign data_out_en = tx_act_q;

    // ------------------------------------------------------------------
    // receive shifter and density decimator
    // ------------------------------------------------------------------
    assign rx_word = {rx_sh_q[30:0], din};
    assign rx_last = cnt_q == FW'(CH_BITS - 1) || cnt_q == FW'(2 * CH_BITS - 1);
    // the counting decimator is a first-order cic: one sample per n bits
    assign den_push = bit_fall && rx_act_q && den_en_q &&
                      den_cnt_q == (dec_sel_q ? 5'(DEC_HI - 1) : 5'(DEC_LO - 1));
    assign rx_push  = den_push || (bit_fall && rx_act_q && !den_en_q && rx_last &&
                                   (!rx_pack_q || cnt_q != FW'(CH_BITS - 1)));
    assign rx_data  = den_en_q ? {26'h0, den_acc_q + 6'(din)} :
                      rx_pack_q ? {rx_word[PACK_BITS-1:0], rx_lo_q} : rx_word;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_sh_q <= '0;
            rx_lo_q <= '0;
        end else if (bit_fall && rx_act_q && !den_en_q) begin
            rx_sh_q <= rx_word;
            if (rx_last && cnt_q == FW'(CH_BITS - 1)) begin
                rx_lo_q <= rx_word[PACK_BITS-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            den_acc_q <= '0;
            den_cnt_q <= '0;
        end else if (!rx_act_q || !den_en_q || den_push) begin
            den_acc_q <= '0;
            den_cnt_q <= '0;
        end else if (bit_fall) begin
            den_acc_q <= den_acc_q + 6'(din);
            den_cnt_q <= den_cnt_q + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_txw_empty;
        (tx_thr_q == THR_EMPTY && f_lvl[0] != '0) |-> !csr_val[TXW_BIT];
    endproperty
    a_txw_empty: assert property (p_txw_empty) else $error("needs-writing set with data present");

    property p_txw_level;
        (tx_thr_q == THR_ALMOST_FULL) |-> (csr_val[TXW_BIT] == (f_lvl[0] != LW'(DEPTH)));
    endproperty
    a_txw_level: assert property (p_txw_level) else $error("needs-writing wrong at full-but-one");

    property p_rx_clear;
        (clr_req[1] && ctrl_en_q && !bit_clock_disable_q) |-> ##[1:200] f_lvl[1] == '0;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("receive fifo not cleared");

    property p_tx_clear;
        (clr_req[0] && ctrl_en_q && !bit_clock_disable_q) |-> ##[1:200] f_lvl[0] == '0;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("transmit fifo not cleared");

    property p_clr_read_zero;
        (ack && !$past(we) && $past(adr) == CSR_OFS) |-> rdata[RX_CLR_BIT:TX_CLR_BIT] == 2'b00;
    endproperty
    a_clr_read_zero: assert property (p_clr_read_zero) else $error("clear bits read nonzero");

    property p_tx_stop;
        ($fell(tx_act_q) && ctrl_en_q) |-> cnt_q == '0;
    endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("transmit stopped mid frame");

    property p_rx_stop;
        ($fell(rx_act_q) && ctrl_en_q) |-> cnt_q == '0;
    endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("receive stopped mid frame");

    property p_frame_start;
        $rose(frame_on_q) |-> (cnt_q == '0 && fs_q && $past(want));
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame start malformed");

    property p_tx_first;
        (slot_load && !frame_on_q && tx_run_q && f_lvl[0] != '0) |-> tx_pop;
    endproperty
    a_tx_first: assert property (p_tx_first) else $error("first word not taken at frame start");

    property p_disabled;
        !ctrl_en_q |=> (!frame_on_q && !bclk_q);
    endproperty
    a_disabled: assert property (p_disabled) else $error("logic active while disabled");

    property p_clk_park;
        (ctrl_en_q && bit_clock_disable_q && !dir_q && !bclk_q) |=> !bclk_q;
    endproperty
    a_clk_park: assert property (p_clk_park) else $error("bit clock ran while disabled");

    c_frame:  cover property ($rose(frame_on_q));
    c_tx_pop: cover property (tx_pop && tx_pack_q);
    c_rx_pus: cover property (rx_push && !den_en_q);
    c_den:    cover property (den_push && dec_sel_q);

endmodule

//--- tb/codec_partner.sv
// codec_partner: far-side audio device with a free-running bit clock and a data loopback
`timescale 1ns/10ps
module codec_partner (
    // serial link
    input  wire logic link_out,
    input  wire logic link_out_en,
    output logic      link_clk,
    output logic      link_in
);
    // ----
    // bit clock
    // ----
    // a codec's bit clock runs free, so it is not stopped between frames; phase unrelated to ref_clk
    initial begin
        link_clk = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end
    // released line toggles each bit so a stale bit never passes for data
    logic idle_q = 1'b0;
    always @(posedge link_clk) idle_q <= ~idle_q;
    assign link_in = link_out_en ? link_out : idle_q;
endmodule

//--- tb/serial_audio_core_tb.sv
// serial_audio_core_tb: register, fifo and loopback checks of the serial audio block
`timescale 1ns/10ps
module serial_audio_core_tb;
    import serial_audio_pkg::*;
    // ----
    // signals
    // ----
    localparam int DEPTH = 4;
    logic        ref_clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic        ack, bclk_drive, bclk_drive_en, fs_drive, data_in, data_out, data_out_en, ext_clk;
    int          err_total = 0, n_compared = 0, cycles = 0;
    always #10 ref_clk = ~ref_clk;
    serial_audio_core #(.DEPTH(DEPTH)) dut_u (.ref_clk(ref_clk), .reset(reset), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .sel(sel), .wdata(wdata), .rdata(rdata), .ack(ack),
        .bclk_pin(bclk_drive_en ? bclk_drive : ext_clk), .bclk_drive(bclk_drive),
        .bclk_drive_en(bclk_drive_en), .fs_drive(fs_drive), .fs_drive_en(), .data_in(data_in),
        .data_out(data_out), .data_out_en(data_out_en));
    codec_partner far_u (.link_out(data_out), .link_out_en(data_out_en), .link_clk(ext_clk), .link_in(data_in));
    // ----
    // helpers
    // ----
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // wait for ack without assuming its latency; a missing ack counts as a mismatch
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdata <= d;
        do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 50);
        q = rdata;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) chk({31'h0, ack}, 32'h1);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        bus(0, CSR_OFS, 0);
        chk(q, 32'h002a_0000);
        bus(0, 4'hc, 0);
        chk(q, 32'h0);
        bus(0, FIFO_OFS, 0);
        chk(q, FIFO_RST);
    endtask
    // fill one past full, every threshold at every level; the last push is dropped
    task automatic t_thresh;
        for (int l = 0; l <= DEPTH; l++) begin
            for (int t = 0; t < 4; t++) begin
                bus(1, CSR_OFS, 32'(t) << TX_THR_LSB);
                bus(0, CSR_OFS, 0);
                chk({q[TXE_BIT], q[TXD_BIT], q[TXW_BIT], q[6:0]}, {l == 0, l < DEPTH, t == 0 ? l == 0 :
                    t == 1 ? l < DEPTH / 4 : t == 2 ? l < 3 * DEPTH / 4 : l < DEPTH, 7'(t << 5)});
            end
            bus(1, FIFO_OFS, 32'h1111_1111 * l);
        end
    endtask
    task automatic t_clear;
        int n;
        n = 0;
        // enable first so the bit clock already runs when the clear is written
        bus(1, CSR_OFS, 32'h01);
        bus(1, CSR_OFS, 32'h19);
        bus(0, CSR_OFS, 0);
        chk({q[TXE_BIT], q[6:0]}, 8'h01);
        repeat (40) @(posedge ref_clk);
        bus(0, CSR_OFS, 0);
        chk({q[TXE_BIT], q[6:0]}, 8'h81);
        bus(1, MODE_OFS, 32'h1 << BIT_CLOCK_DISABLE_BIT);
        repeat (8) @(posedge ref_clk);
        repeat (24) begin @(posedge ref_clk); if (bclk_drive !== 1'b0) n++; end
        chk(32'(n), 0);
        bus(1, MODE_OFS, 0);
        bus(1, CSR_OFS, 0);
    endtask
    // one frame sent and looped back, runs dropped in mid-frame; e0/e1 are the words read back
    task automatic t_loop(input logic [31:0] mode, input logic [31:0] e0, input logic [31:0] e1);
        int n;
        n = 0;
        bus(1, MODE_OFS, mode);
        chk({31'h0, bclk_drive_en}, {31'h0, ~mode[DIR_BIT]});
        bus(1, FIFO_OFS, 32'ha5c3_0f96);
        bus(1, FIFO_OFS, 32'h5a3c_f069);
        bus(1, CSR_OFS, 32'h07);
        while (fs_drive !== 1'b1 && n < 2000) begin @(posedge ref_clk); n++; end
        chk({data_out_en, data_out}, {1'b1, ~mode[TX_PACK_BIT]});
        bus(1, CSR_OFS, 32'h01);
        repeat (700) @(posedge ref_clk);
        chk(data_out_en, 0);
        bus(0, FIFO_OFS, 0);
        chk(q, e0);
        bus(0, FIFO_OFS, 0);
        chk(q, e1);
        bus(0, CSR_OFS, 0);
        chk(q[RXD_BIT], 0);
        // packed transmit leaves a word behind; clear it while the bit clock still runs
        bus(1, CSR_OFS, 32'h19);
        repeat (40) @(posedge ref_clk);
        bus(0, CSR_OFS, 0);
        chk(q[TXE_BIT], 1);
        bus(1, CSR_OFS, 0);
    endtask
    // density input: the idle far side toggles every bit, so each window holds half ones
    task automatic t_density(input logic sel32);
        bus(1, MODE_OFS, (32'h1 << DEN_EN_BIT) | (32'(sel32) << DEN_SEL_BIT));
        bus(1, CSR_OFS, 32'h03);
        repeat (300) @(posedge ref_clk);
        bus(1, CSR_OFS, 32'h01);
        repeat (600) @(posedge ref_clk);
        bus(0, FIFO_OFS, 0);
        chk(q, sel32 ? 32'h10 : 32'h08);
        bus(1, CSR_OFS, 32'h11);
        repeat (40) @(posedge ref_clk);
        bus(0, CSR_OFS, 0);
        chk(q[RXD_BIT], 0);
        bus(1, CSR_OFS, 0);
        bus(1, MODE_OFS, 0);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset;
        t_thresh;
        t_clear;
        t_loop(0, 32'ha5c3_0f96, 32'h5a3c_f069);
        t_loop(32'h1 << DIR_BIT, 32'ha5c3_0f96, 32'h5a3c_f069);
        t_loop(32'h1 << RX_PACK_BIT, 32'hf069_0f96, 32'h0);
        t_loop(32'h1 << TX_PACK_BIT, 32'h0f96_0000, 32'ha5c3_0000);
        t_density(1'b0);
        t_density(1'b1);
        test_done;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin err_total++; test_done; end
    end
endmodule
